// File: twsc_serial_control.sv
`default_nettype none
module twsc_serial_control (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic                 pready,
	output var  logic [31:0]          prdata,
	output var  logic                 pslverr,
	// rate source
	input  wire logic                 timer1_overflow,
	// bus lines, open drain
	input  wire twsc_pkg::twsc_line_t line_in,
	output var  twsc_pkg::twsc_line_t line_out,
	output var  twsc_pkg::twsc_line_t line_oe,
	// interrupt
	output var  logic                 irq
);
	import twsc_pkg::*;

	twsc_ctrl_t              ctrl_reg, ctrl_next;
	twsc_addr_t              own_reg, own_next;
	logic [7:0]              status_reg, status_next;
	logic [IRQ_W-1:0]        istat_reg, istat_next;
	logic [IRQ_W-1:0]        ien_reg, ien_next;
	logic                    irq_reg, irq_next;
	logic                    pready_reg, pready_next;
	logic [31:0]             prdata_reg, prdata_next;
	logic                    pslverr_reg, pslverr_next;
	logic                    acc, wr, data_wr, mapped;

	twsc_state_t             state_reg, state_next;
	logic [1:0]              phase_reg, phase_next;
	logic [3:0]              bitcnt_reg, bitcnt_next;
	logic [7:0]              shift_reg, shift_next;
	logic [7:0]              code_reg, code_next;
	logic [CNT_W-1:0]        div_reg, div_next;
	twsc_line_t              oe_reg, oe_next;
	twsc_line_t              out_reg;
	twsc_line_t              prev_reg;
	logic                    master_reg, master_next;
	logic                    rx_reg, rx_next;
	logic                    dir_rx_reg, dir_rx_next;
	logic                    aphase_reg, aphase_next;
	logic                    addressed_reg, addressed_next;
	logic                    gc_reg, gc_next;
	logic                    busy_reg, busy_next;
	logic                    ack_reg, ack_next;
	logic                    si_set, stop_done, arb_lost;
	logic                    tick, tmode, own_hit, gc_hit;
	logic [CNT_W-1:0]        lim;
	logic                    bus_start, bus_stop, scl_rise, scl_fall;

	function automatic logic [CNT_W-1:0] tick_lim(input logic [2:0] r);
		int d;
		unique case (r)
			3'h0: d = DIV_0;
			3'h1: d = DIV_1;
			3'h2: d = DIV_2;
			3'h3: d = DIV_3;
			3'h4: d = DIV_4;
			3'h5: d = DIV_5;
			3'h6: d = DIV_6;
			3'h7: d = T1_DIV;
		endcase
		return CNT_W'(d / PHASES - 1);
	endfunction : tick_lim

	// bus condition detect
	assign bus_start = line_in.scl & prev_reg.scl & prev_reg.sda & ~line_in.sda;
	assign bus_stop  = line_in.scl & prev_reg.scl & ~prev_reg.sda & line_in.sda;
	assign scl_rise  = line_in.scl & ~prev_reg.scl;
	assign scl_fall  = ~line_in.scl & prev_reg.scl;
	assign own_hit   = shift_reg[7:1] == own_reg.addr;
	// general call compare
	assign gc_hit    = own_reg.general_call_enable & (shift_reg[7:1] == GEN_CALL_ADDR);

	// bit rate tick
	always_comb begin
		lim   = tick_lim({ctrl_reg.rate_select_hi, ctrl_reg.rate_select_mid,
			ctrl_reg.rate_select_lo});
		tmode = {ctrl_reg.rate_select_hi, ctrl_reg.rate_select_mid,
			ctrl_reg.rate_select_lo} == RATE_TIMER;
		// at or past limit, so a rate code with a shorter limit takes effect at once
		tick  = (div_reg >= lim) & (~tmode | timer1_overflow);
		if (tick)
			div_next = '0;
		else if (~tmode | timer1_overflow)
			div_next = div_reg + CNT_W'(1);
		else
			div_next = div_reg;
	end

	// serial engine
	always_comb begin
		state_next     = state_reg;
		phase_next     = phase_reg;
		bitcnt_next    = bitcnt_reg;
		shift_next     = shift_reg;
		code_next      = code_reg;
		oe_next        = oe_reg;
		master_next    = master_reg;
		rx_next        = rx_reg;
		dir_rx_next    = dir_rx_reg;
		aphase_next    = aphase_reg;
		addressed_next = addressed_reg;
		gc_next        = gc_reg;
		ack_next       = ack_reg;
		si_set         = 1'b0;
		stop_done      = 1'b0;
		arb_lost       = 1'b0;
		busy_next      = bus_start ? 1'b1 : (bus_stop ? 1'b0 : busy_reg);
		if (data_wr)
			shift_next = pwdata[7:0];
		if (!ctrl_reg.interface_enable) begin
			state_next     = ST_IDLE;
			oe_next        = '0;
			master_next    = 1'b0;
			addressed_next = 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					oe_next = '0;
					if (ctrl_reg.start_request && !busy_reg) begin
						state_next = ST_START;
						phase_next = PH_A;
					end else if (bus_start && ctrl_reg.ack_control) begin
						state_next  = ST_SBIT;
						bitcnt_next = '0;
						rx_next     = 1'b1;
						aphase_next = 1'b1;
					end
				end
				ST_START: if (tick) begin
					unique case (phase_reg)
						PH_A: begin
							oe_next.sda = 1'b0;
							phase_next  = PH_B;
						end
						PH_B: begin
							oe_next.scl = 1'b0;
							phase_next  = PH_C;
						end
						PH_C: if (line_in.scl) begin
							oe_next.sda = 1'b1;
							phase_next  = PH_D;
						end
						PH_D: begin
							oe_next.scl = 1'b1;
							code_next   = master_reg ? SC_RSTART : SC_START;
							master_next = 1'b1;
							aphase_next = 1'b1;
							dir_rx_next = 1'b0;
							si_set      = 1'b1;
							state_next  = ST_WAIT;
						end
					endcase
				end
				ST_WAIT: begin
					oe_next.scl = 1'b1;
					if (!ctrl_reg.int_flag) begin
						phase_next  = PH_A;
						bitcnt_next = '0;
						if (ctrl_reg.stop_request && master_reg)
							state_next = ST_STOP;
						else if (ctrl_reg.start_request)
							state_next = ST_START;
						else if (master_reg) begin
							state_next = ST_MBIT;
							rx_next    = dir_rx_reg & ~aphase_reg;
						end else if (addressed_reg) begin
							state_next  = ST_SBIT;
							rx_next     = dir_rx_reg;
							aphase_next = 1'b0;
							oe_next.scl = 1'b0;
							oe_next.sda = ~dir_rx_reg & ~shift_reg[7];
						end else begin
							state_next = ST_IDLE;
							oe_next    = '0;
						end
					end
				end
				ST_MBIT, ST_MACK: if (tick) begin
					unique case (phase_reg)
						PH_A: begin
							if (state_reg == ST_MACK)
								oe_next.sda = rx_reg & ctrl_reg.ack_control;
							else
								oe_next.sda = ~rx_reg & ~shift_reg[7];
							phase_next = PH_B;
						end
						PH_B: begin
							oe_next.scl = 1'b0;
							phase_next  = PH_C;
						end
						PH_C: if (line_in.scl) begin
							oe_next.scl = 1'b1;
							phase_next  = PH_A;
							if (state_reg == ST_MACK) begin
								oe_next.sda = 1'b0;
								si_set      = 1'b1;
								state_next  = ST_WAIT;
								aphase_next = 1'b0;
								if (aphase_reg) begin
									dir_rx_next = shift_reg[0];
									if (shift_reg[0])
										code_next = line_in.sda ? SC_AR_NACK : SC_AR_ACK;
									else
										code_next = line_in.sda ? SC_AW_NACK : SC_AW_ACK;
								end else if (rx_reg)
									code_next = ctrl_reg.ack_control ? SC_RXD_ACK : SC_RXD_NACK;
								else
									code_next = line_in.sda ? SC_TXD_NACK : SC_TXD_ACK;
							end else if (!rx_reg && !oe_reg.sda && !line_in.sda) begin
								oe_next     = '0;
								master_next = 1'b0;
								code_next   = SC_ARB_LOST;
								arb_lost    = 1'b1;
								si_set      = 1'b1;
								state_next  = ST_WAIT;
							end else begin
								shift_next  = {shift_reg[6:0], line_in.sda};
								bitcnt_next = bitcnt_reg + 4'h1;
								if (bitcnt_reg == BYTE_BITS - 4'h1)
									state_next = ST_MACK;
							end
						end
						default: phase_next = PH_A;
					endcase
				end
				ST_STOP: if (tick) begin
					unique case (phase_reg)
						PH_A: begin
							oe_next.sda = 1'b1;
							phase_next  = PH_B;
						end
						PH_B: begin
							oe_next.scl = 1'b0;
							phase_next  = PH_C;
						end
						PH_C: if (line_in.scl) begin
							oe_next.sda = 1'b0;
							stop_done   = 1'b1;
							master_next = 1'b0;
							state_next  = ST_IDLE;
						end
						default: phase_next = PH_A;
					endcase
				end
				ST_SBIT, ST_SACK: begin
					if (bus_stop) begin
						oe_next        = '0;
						addressed_next = 1'b0;
						if (addressed_reg) begin
							code_next  = SC_SLV_STOP;
							si_set     = 1'b1;
							state_next = ST_WAIT;
						end else
							state_next = ST_IDLE;
					end else if (bus_start) begin
						oe_next        = '0;
						state_next     = ST_SBIT;
						bitcnt_next    = '0;
						rx_next        = 1'b1;
						aphase_next    = 1'b1;
						addressed_next = 1'b0;
					end else if (state_reg == ST_SBIT) begin
						if (scl_rise) begin
							shift_next  = {shift_reg[6:0], line_in.sda};
							bitcnt_next = bitcnt_reg + 4'h1;
						end else if (scl_fall && bitcnt_reg == BYTE_BITS) begin
							state_next = ST_SACK;
							if (!rx_reg)
								oe_next.sda = 1'b0;
							else if (aphase_reg) begin
								if (ctrl_reg.ack_control && (own_hit || gc_hit)) begin
									oe_next.sda    = 1'b1;
									addressed_next = 1'b1;
									gc_next        = ~own_hit;
									dir_rx_next    = ~(own_hit & shift_reg[0]);
									if (!own_hit)
										code_next = SC_SGC_ADDR;
									else
										code_next = shift_reg[0] ? SC_SR_ADDR : SC_SW_ADDR;
								end else begin
									oe_next    = '0;
									state_next = ST_IDLE;
								end
							end else begin
								oe_next.sda = ctrl_reg.ack_control;
								if (gc_reg)
									code_next = ctrl_reg.ack_control ? SC_SGC_ACK : SC_SGC_NACK;
								else
									code_next = ctrl_reg.ack_control ? SC_SRX_ACK : SC_SRX_NACK;
							end
						end else if (scl_fall && !rx_reg)
							oe_next.sda = ~shift_reg[7];
					end else begin
						if (scl_rise)
							ack_next = ~line_in.sda;
						else if (scl_fall) begin
							oe_next.sda = 1'b0;
							oe_next.scl = 1'b1;
							si_set      = 1'b1;
							state_next  = ST_WAIT;
							if (!rx_reg) begin
								code_next      = ack_reg ? SC_STX_ACK : SC_STX_NACK;
								addressed_next = ack_reg;
							end
						end
					end
				end
			endcase
		end
	end

	// apb and registers
	always_comb begin
		ctrl_next    = ctrl_reg;
		own_next     = own_reg;
		istat_next   = istat_reg;
		ien_next     = ien_reg;
		acc          = psel & penable & pready_reg;
		wr           = acc & pwrite;
		data_wr      = wr & (paddr == OFS_DATA) & ctrl_reg.int_flag;
		pready_next  = psel & penable & ~pready_reg;
		mapped       = paddr inside {OFS_CTRL, OFS_STATUS, OFS_OWN_ADDR, OFS_DATA,
			OFS_IRQ_STAT, OFS_IRQ_EN, OFS_IRQ_CLR};
		pslverr_next = pready_next & ~mapped;
		prdata_next  = '0;
		if (pready_next && !pwrite) begin
			unique case (paddr)
				OFS_CTRL:     prdata_next[7:0] = ctrl_reg;
				OFS_STATUS:   prdata_next[7:0] = status_reg;
				OFS_OWN_ADDR: prdata_next[7:0] = own_reg;
				OFS_DATA:     prdata_next[7:0] = shift_reg;
				OFS_IRQ_STAT: prdata_next[IRQ_W-1:0] = istat_reg;
				OFS_IRQ_EN:   prdata_next[IRQ_W-1:0] = ien_reg;
				default:      prdata_next = '0;
			endcase
		end
		if (wr) begin
			unique case (paddr)
				OFS_CTRL: begin
					ctrl_next          = pwdata[7:0];
					ctrl_next.int_flag = ctrl_reg.int_flag & pwdata[4'h3];
				end
				OFS_OWN_ADDR: own_next = pwdata[7:0];
				OFS_IRQ_EN:   ien_next = pwdata[IRQ_W-1:0];
				OFS_IRQ_CLR:  istat_next = istat_reg & ~pwdata[IRQ_W-1:0];
				default:      ;
			endcase
		end
		if (stop_done)
			ctrl_next.stop_request = 1'b0;
		if (si_set)
			ctrl_next.int_flag = 1'b1;
		istat_next[IRQ_SI]  = istat_next[IRQ_SI] | si_set;
		istat_next[IRQ_STP] = istat_next[IRQ_STP] | stop_done;
		istat_next[IRQ_ARB] = istat_next[IRQ_ARB] | arb_lost;
		status_next = ctrl_reg.int_flag ? code_reg : SC_NONE;
		irq_next    = |(istat_reg & ien_reg);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg      <= CTRL_RESET;
			own_reg       <= ADDR_RESET;
			status_reg    <= SC_NONE;
			istat_reg     <= '0;
			ien_reg       <= '0;
			irq_reg       <= 1'b0;
			pready_reg    <= 1'b0;
			prdata_reg    <= '0;
			pslverr_reg   <= 1'b0;
			state_reg     <= ST_IDLE;
			phase_reg     <= PH_A;
			bitcnt_reg    <= '0;
			shift_reg     <= DATA_RESET;
			code_reg      <= SC_NONE;
			div_reg       <= '0;
			oe_reg        <= '0;
			out_reg       <= '0;
			prev_reg      <= '1;
			master_reg    <= 1'b0;
			rx_reg        <= 1'b0;
			dir_rx_reg    <= 1'b0;
			aphase_reg    <= 1'b0;
			addressed_reg <= 1'b0;
			gc_reg        <= 1'b0;
			busy_reg      <= 1'b0;
			ack_reg       <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			own_reg       <= own_next;
			status_reg    <= status_next;
			istat_reg     <= istat_next;
			ien_reg       <= ien_next;
			irq_reg       <= irq_next;
			pready_reg    <= pready_next;
			prdata_reg    <= prdata_next;
			pslverr_reg   <= pslverr_next;
			state_reg     <= state_next;
			phase_reg     <= phase_next;
			bitcnt_reg    <= bitcnt_next;
			shift_reg     <= shift_next;
			code_reg      <= code_next;
			div_reg       <= div_next;
			oe_reg        <= oe_next;
			out_reg       <= '0;
			prev_reg      <= line_in;
			master_reg    <= master_next;
			rx_reg        <= rx_next;
			dir_rx_reg    <= dir_rx_next;
			aphase_reg    <= aphase_next;
			addressed_reg <= addressed_next;
			gc_reg        <= gc_next;
			busy_reg      <= busy_next;
			ack_reg       <= ack_next;
		end
	end

	assign pready   = pready_reg;
	assign prdata   = prdata_reg;
	assign pslverr  = pslverr_reg;
	assign irq      = irq_reg;
	assign line_oe  = oe_reg;
	assign line_out = out_reg;
endmodule : twsc_serial_control
`default_nettype wire

// File: twsc_pkg.sv
`default_nettype none
package twsc_pkg;
	// apb register map, byte addresses
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_OWN_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA     = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'hff;

	// status codes
	localparam logic [7:0] SC_NONE       = 8'hf8;
	localparam logic [7:0] SC_START      = 8'h08;
	localparam logic [7:0] SC_RSTART     = 8'h10;
	localparam logic [7:0] SC_AW_ACK     = 8'h18;
	localparam logic [7:0] SC_AW_NACK    = 8'h20;
	localparam logic [7:0] SC_TXD_ACK    = 8'h28;
	localparam logic [7:0] SC_TXD_NACK   = 8'h30;
	localparam logic [7:0] SC_ARB_LOST   = 8'h38;
	localparam logic [7:0] SC_AR_ACK     = 8'h40;
	localparam logic [7:0] SC_AR_NACK    = 8'h48;
	localparam logic [7:0] SC_RXD_ACK    = 8'h50;
	localparam logic [7:0] SC_RXD_NACK   = 8'h58;
	localparam logic [7:0] SC_SW_ADDR    = 8'h60;
	localparam logic [7:0] SC_SGC_ADDR   = 8'h70;
	localparam logic [7:0] SC_SRX_ACK    = 8'h80;
	localparam logic [7:0] SC_SRX_NACK   = 8'h88;
	localparam logic [7:0] SC_SGC_ACK    = 8'h90;
	localparam logic [7:0] SC_SGC_NACK   = 8'h98;
	localparam logic [7:0] SC_SLV_STOP   = 8'ha0;
	localparam logic [7:0] SC_SR_ADDR    = 8'ha8;
	localparam logic [7:0] SC_STX_ACK    = 8'hb8;
	localparam logic [7:0] SC_STX_NACK   = 8'hc0;
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

	// bit rate: clocks per bit for each rate code, timer overflows per bit
	localparam int DIV_0      = 256;
	localparam int DIV_1      = 224;
	localparam int DIV_2      = 192;
	localparam int DIV_3      = 160;
	localparam int DIV_4      = 960;
	localparam int DIV_5      = 120;
	localparam int DIV_6      = 60;
	localparam int T1_DIV     = 96;
	localparam int PHASES     = 3;
	localparam int CNT_W      = 10;
	localparam logic [2:0] RATE_TIMER = 3'h7;
	localparam logic [3:0] BYTE_BITS  = 4'h8;

	// phases of one bit
	localparam logic [1:0] PH_A = 2'h0;
	localparam logic [1:0] PH_B = 2'h1;
	localparam logic [1:0] PH_C = 2'h2;
	localparam logic [1:0] PH_D = 2'h3;

	// interrupt status bits
	localparam int IRQ_W   = 3;
	localparam int IRQ_SI  = 0;
	localparam int IRQ_STP = 1;
	localparam int IRQ_ARB = 2;

	typedef struct packed {
		logic rate_select_hi;
		logic interface_enable;
		logic start_request;
		logic stop_request;
		logic int_flag;
		logic ack_control;
		logic rate_select_mid;
		logic rate_select_lo;
	} twsc_ctrl_t;

	typedef struct packed {
		logic [6:0] addr;
		logic       general_call_enable;
	} twsc_addr_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} twsc_line_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_START, ST_WAIT, ST_MBIT, ST_MACK, ST_STOP, ST_SBIT, ST_SACK
	} twsc_state_t;
endpackage : twsc_pkg
`default_nettype wire

// File: twsc_serial_control_assertions.sv
`default_nettype none
module twsc_serial_control_assertions import twsc_pkg::*; (
	// apb side
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	// serial side
	input wire logic                 timer1_overflow,
	input wire twsc_pkg::twsc_line_t line_in,
	input wire twsc_pkg::twsc_line_t line_out,
	input wire twsc_pkg::twsc_line_t line_oe,
	input wire logic                 irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic acc;
	logic wr_ctrl;
	assign acc = psel && penable && pready;
	assign wr_ctrl = acc && pwrite && paddr == OFS_CTRL;
	wait_state_a: assert property ($rose(penable) && psel |=> pready)
		else $error("no ready after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (acc |-> pslverr == (paddr > OFS_IRQ_CLR || paddr[1:0] != 2'h0))
		else $error("wrong error response");
	idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	open_drain_a: assert property (line_out == 2'b00)
		else $error("line driven high");
	disable_release_a: assert property (wr_ctrl && !pwdata[6] |-> ##[1:2] line_oe == 2'b00)
		else $error("lines not released");
	flag_holds_scl_a: assert property (
		acc && !pwrite && paddr == OFS_CTRL && prdata[3] |-> ##[0:1] line_oe.scl)
		else $error("clock line free while flag set");
	status_format_a: assert property (
		acc && !pwrite && paddr == OFS_STATUS |-> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
		else $error("status code malformed");
	start_sda_a: assert property (
		wr_ctrl && pwdata[6:5] == 2'b11 && line_oe == 2'b00 && line_in == 2'b11
		|-> ##[1:1000] line_oe.sda)
		else $error("no start sent");
	irq_mask_a: assert property (acc && pwrite && paddr == OFS_IRQ_EN && pwdata[2:0] == 3'h0
		|=> ##1 !irq)
		else $error("irq high while masked");
	stop_cv: cover property (wr_ctrl && pwdata[4]);
	err_cv: cover property (acc && pslverr);
	hold_cv: cover property (line_oe.scl && irq);
endmodule : twsc_serial_control_assertions
bind twsc_serial_control twsc_serial_control_assertions chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.timer1_overflow(timer1_overflow), .line_in(line_in), .line_out(line_out),
	.line_oe(line_oe), .irq(irq)
);
`default_nettype wire

// File: twsc_bus_peer.sv
`default_nettype none
module twsc_bus_peer (
	// wire levels
	input  wire logic       scl,
	input  wire logic       sda,
	// peer setup
	input  wire logic [6:0] my_addr,
	input  wire logic [7:0] tx_byte,
	// peer outputs
	output var  logic       sda_pull,
	output var  logic       ack_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	int         bit_n = 0;
	logic       addr_ph = 1'b0;
	logic       rd = 1'b0;
	logic       hit = 1'b0;
	logic [7:0] rx = 8'h00;
	initial begin
		sda_pull = 1'b0;
		ack_seen = 1'b0;
	end
	// start opens a frame, stop closes it
	always @(sda) begin
		if (scl === 1'b1) begin
			bit_n = -1;
			addr_ph = !sda;
			hit = 1'b0;
			sda_pull = 1'b0;
		end
	end
	// sample bits, master ack ends a read on nack
	always @(posedge scl) begin
		if (bit_n >= 0 && bit_n < 8)
			rx = {rx[6:0], sda};
		else if (bit_n == 8 && !addr_ph && rd && hit) begin
			ack_seen = !sda;
			hit = !sda;
		end
	end
	// drive the next slot while clock is low
	always @(negedge scl) begin
		bit_n = bit_n + 1;
		if (bit_n == 9) begin
			bit_n = 0;
			addr_ph = 1'b0;
		end
		if (bit_n == 8 && addr_ph) begin
			hit = rx[7:1] == my_addr;
			rd = rx[0];
		end
		if (bit_n == 8)
			sda_pull = hit && (addr_ph || !rd);
		else
			sda_pull = hit && rd && !addr_ph && !tx_byte[7 - bit_n];
	end
endmodule : twsc_bus_peer
`default_nettype wire

// File: twsc_serial_control_tb.sv
`default_nettype none
module twsc_serial_control_tb import twsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        t1_ovf = 1'b0, pready, pslverr, irq, sda_pull, ack_seen, err;
	logic        m_scl = 1'b0, m_sda = 1'b0;
	logic [2:0]  c;
	logic [6:0]  peer_addr = 7'h00;
	logic [7:0]  paddr = 8'h00, tx_byte = 8'h00, sb;
	logic [31:0] pwdata = 32'h0, prdata, rd, rng = 32'hd55656b2;
	twsc_line_t  line_in, line_out, line_oe;
	int          n_errors = 0, checks_done = 0, tw, t6, k;
	logic [7:0]  ofs[5] = '{OFS_CTRL, OFS_STATUS, OFS_OWN_ADDR, OFS_DATA, 8'h40};
	logic [7:0]  rst_val[5] = '{CTRL_RESET, SC_NONE, ADDR_RESET, DATA_RESET, 8'h00};
	logic [2:0]  codes[8] = '{3'h6, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	int          tks[8] = '{DIV_0 / PHASES, DIV_1 / PHASES, DIV_2 / PHASES, DIV_3 / PHASES,
		DIV_4 / PHASES, DIV_5 / PHASES, DIV_6 / PHASES, 2 * T1_DIV / PHASES};
	always #25 pclk = ~pclk;
	always @(posedge pclk) t1_ovf <= !t1_ovf;
	always_comb begin
		line_in.scl = !(line_oe.scl || m_scl);
		line_in.sda = !(line_oe.sda || sda_pull || m_sda);
	end
	twsc_serial_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .timer1_overflow(t1_ovf), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .irq(irq));
	twsc_bus_peer peer (.scl(line_in.scl), .sda(line_in.sda), .my_addr(peer_addr),
		.tx_byte(tx_byte), .sda_pull(sda_pull), .ack_seen(ack_seen));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", pready, 1'b1);
	endtask : apb
	task automatic step(input logic [7:0] cv, input logic [7:0] st);
		apb(1'b1, OFS_CTRL, {24'h0, cv});
		tw = 0;
		while (irq !== 1'b1 && tw < 20000) begin
			@(posedge pclk);
			tw++;
		end
		apb(1'b1, OFS_IRQ_CLR, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", rd, {24'h0, st});
	endtask : step
	task automatic stop_tx();
		int n;
		n = 0;
		apb(1'b1, OFS_CTRL, 32'hd2);
		do begin
			apb(1'b0, OFS_CTRL, 32'h0);
			n++;
		end while (rd[4] !== 1'b0 && n < 200);
		chk("stop_request", rd[4], 1'b0);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		chk("stop_done", rd[1], 1'b1);
		chk("irq_masked", irq, 1'b0);
		apb(1'b1, OFS_IRQ_EN, 32'h3);
		repeat (2) @(posedge pclk);
		chk("irq_on", irq, 1'b1);
		apb(1'b1, OFS_IRQ_CLR, 32'h7);
		apb(1'b1, OFS_IRQ_EN, 32'h1);
		chk("irq_off", irq, 1'b0);
	endtask : stop_tx
	task automatic bang(input logic s, input logic d);
		@(posedge pclk);
		m_scl <= s;
		m_sda <= d;
		repeat (4) @(posedge pclk);
	endtask : bang
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (100000) @(posedge pclk);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, OFS_STATUS, 32'h55);
		apb(1'b1, OFS_DATA, 32'h12);
		foreach (ofs[i]) begin
			apb(1'b0, ofs[i], 32'h0);
			chk("reg", rd, {24'h0, rst_val[i]});
			chk("slverr", err, ofs[i] > OFS_IRQ_CLR);
		end
		rng = xs(rng);
		peer_addr = rng[7:1] | 7'h01;
		apb(1'b1, OFS_OWN_ADDR, {24'h0, peer_addr ^ 7'h40, rng[8]});
		apb(1'b0, OFS_OWN_ADDR, 32'h0);
		chk("own_addr", rd, {24'h0, peer_addr ^ 7'h40, rng[8]});
		$display("registers done");
		apb(1'b1, OFS_IRQ_EN, 32'h1);
		foreach (codes[i]) begin
			c = codes[i];
			step({c[2], 5'b11000, c[1:0]}, SC_START);
			apb(1'b0, OFS_CTRL, 32'h0);
			chk("flag", rd[3], 1'b1);
			chk("scl_hold", line_oe.scl, 1'b1);
			if (i == 0)
				t6 = tw;
			k = (t6 + tks[6] / 2) / tks[6];
			chk("rate", tw >= (k - 2) * tks[c] && tw <= (k + 1) * tks[c] + 20, 1'b1);
			stop_tx();
		end
		$display("rates done");
		for (int m = 0; m < 4; m++) begin
			step(8'he2, SC_START);
			apb(1'b1, OFS_DATA, {24'h0, m[1] ? peer_addr : peer_addr ^ 7'h01, 1'b0});
			step(m[0] ? 8'hc6 : 8'hc2, m[1] ? SC_AW_ACK : SC_AW_NACK);
			stop_tx();
		end
		$display("transmit done");
		for (int m = 0; m < 2; m++) begin
			rng = xs(rng);
			tx_byte = rng[7:0];
			step(8'he2, SC_START);
			apb(1'b1, OFS_DATA, {24'h0, peer_addr, 1'b1});
			step(8'hc6, SC_AR_ACK);
			step(m ? 8'hc6 : 8'hc2, m ? SC_RXD_ACK : SC_RXD_NACK);
			apb(1'b0, OFS_DATA, 32'h0);
			chk("rx_data", rd, {24'h0, tx_byte});
			chk("ack_seen", ack_seen, m[0]);
			if (m)
				step(8'hc2, SC_RXD_NACK);
			stop_tx();
		end
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFS_OWN_ADDR, {24'h0, peer_addr ^ 7'h40, m == 3});
			apb(1'b1, OFS_CTRL, m ? 32'h44 : 32'h40);
			sb = m[1] ? 8'h00 : {peer_addr ^ 7'h40, 1'b0};
			bang(1'b0, 1'b1);
			for (int b = 7; b >= 0; b--) begin
				bang(1'b1, !sb[b]);
				bang(1'b0, !sb[b]);
			end
			bang(1'b1, 1'b0);
			bang(1'b0, 1'b0);
			chk("slave_ack", !line_in.sda, m[0]);
			bang(1'b1, 1'b0);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk("slave_code", rd, {24'h0, m[0] ? (m[1] ? SC_SGC_ADDR : SC_SW_ADDR) : SC_NONE});
			apb(1'b1, OFS_CTRL, 32'h0);
			bang(1'b1, 1'b1);
			bang(1'b0, 1'b1);
			bang(1'b0, 1'b0);
		end
		apb(1'b1, OFS_IRQ_CLR, 32'h7);
		$display("slave done");
		step(8'he2, SC_START);
		apb(1'b1, OFS_IRQ_EN, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		chk("release", line_oe, 2'b00);
		$display("receive and disable done");
		print_verdict();
	end
endmodule : twsc_serial_control_tb
`default_nettype wire
